// ---- rtl/sllms_defs.vh ----
// Purpose: Shared offsets, field positions, reset values and limits for the lane map and sync block.
// Assumes: Register offsets are byte addresses on the documented 12-bit register port.
// Notes: Every value used by more than one place lives here and only here.
// Behaviour
// - Link enable field: 1 enables link 0 alone, 3 enables both links.
// - Status link select bit chooses link 0 or link 1 status readback.
// - Measured latency counts processing clocks, wraps to zero at the multiframe boundary.
// - Variable window above 10 processing clocks is unsupported and flagged.
// - Eight three-bit lane source fields, two per register, at 0x308 to 0x30B.
// - Reset maps logical lane y to physical lane y; writing x selects lane x.
// - Lanes form one or two links sharing one SYSREF and one clock.
// - Lanes are descrambled in the link layer then passed as deframed words.
// - Single link uses sync output 0 for all lanes; dual uses both.
// - Any unsynchronised lane of a link raises that link's sync request.
// - Lane rate must stay between 1.44 and 12.4 Gbps; violations are flagged.
// - Single link supports modes 0 to 7, 9 and 10.
// - Dual link supports modes 4 to 7, 9 and 10 on each link.
// - The block clock is the processing clock, one fortieth of lane rate.
// - Two-link mode bit selects one link or two independent links.
`ifndef SLLMS_DEFS_VH
`define SLLMS_DEFS_VH

`define SLLMS_ADDR_LINK_CTRL   12'h300
`define SLLMS_ADDR_SUBCLASS    12'h301
`define SLLMS_ADDR_LAT0        12'h302
`define SLLMS_ADDR_LAT1        12'h303
`define SLLMS_ADDR_STATUS      12'h304
`define SLLMS_ADDR_MAP_A       12'h308
`define SLLMS_ADDR_MAP_B       12'h309
`define SLLMS_ADDR_MAP_C       12'h30A
`define SLLMS_ADDR_MAP_D       12'h30B
`define SLLMS_ADDR_PCPMF       12'h30D
`define SLLMS_ADDR_VARWIN      12'h30E
`define SLLMS_ADDR_RELDEL      12'h30F
`define SLLMS_ADDR_MODE        12'h310
`define SLLMS_ADDR_RATE_LO     12'h311
`define SLLMS_ADDR_RATE_HI     12'h312

`define SLLMS_CTRL_TWO_LINK    3
`define SLLMS_CTRL_STAT_SEL    2
`define SLLMS_MODE_SCRAMBLE    7

`define SLLMS_RST_LINK_CTRL    4'h0
`define SLLMS_RST_PCPMF        6'h20
`define SLLMS_RST_VARWIN       4'h0
`define SLLMS_RST_RELDEL       5'h00
`define SLLMS_RST_MODE         4'h0
`define SLLMS_RST_RATE         11'h3E8

`define SLLMS_MAX_VARWIN       4'hA
`define SLLMS_RATE_MIN_10M     11'h090
`define SLLMS_RATE_MAX_10M     11'h4D8
`define SLLMS_INVALID_MODE     4'h8
`define SLLMS_LAST_MODE        4'hA
`define SLLMS_FIRST_DUAL_MODE  4'h4

`endif

// ---- rtl/sllms_xbar.v ----
// Purpose: Maps eight physical lanes onto eight logical deframer lanes.
// Assumes: Lane words and lane flags arrive on the processing clock.
// Notes: Output is registered, so a changed select acts one cycle later.
`timescale 1ns/1ps
module sllms_xbar
(
	input  wire         clk,
	input  wire         rst,
	input  wire [255:0] phys_data,
	input  wire [7:0]   phys_synced,
	input  wire [7:0]   phys_mf,
	input  wire [23:0]  lane_source_select,
	output reg  [255:0] log_data,
	output reg  [7:0]   log_synced,
	output reg  [7:0]   log_mf
);

	genvar y;
	generate
		for (y = 0; y < 8; y = y + 1)
		begin : g_lane
			wire [2:0] src = lane_source_select[3*y +: 3];
			always @(posedge clk)
			begin
				if (rst)
				begin
					log_data[32*y +: 32] <= 32'h0000_0000;
					log_synced[y]        <= 1'b0;
					log_mf[y]            <= 1'b0;
				end
				else
				begin
					log_data[32*y +: 32] <= phys_data[32*src +: 32];
					log_synced[y]        <= phys_synced[src];
					log_mf[y]            <= phys_mf[src];
				end
			end
		end
	endgenerate

endmodule // sllms_xbar

// ---- rtl/sllms_descr.v ----
// Purpose: Self-synchronous descrambler, 1 + x^14 + x^15, for one 32-bit lane word.
// Assumes: Bit 31 is the earliest bit on the wire.
// Notes: History follows received bits, so a bad word corrupts at most two words.
`timescale 1ns/1ps
module sllms_descr
(
	input  wire        clk,
	input  wire        rst,
	input  wire        scramble_on,
	input  wire        lane_active,
	input  wire [31:0] din,
	output reg  [31:0] dout,
	output reg         dvalid
);

	reg  [14:0] hist_q;
	reg  [31:0] plain;
	wire [46:0] seq = {hist_q, din};
	integer     j;

	// Each output bit undoes the taps fourteen and fifteen bits earlier.
	always @*
	begin
		plain = 32'h0000_0000;
		for (j = 0; j < 32; j = j + 1)
			plain[j] = seq[j] ^ seq[j+14] ^ seq[j+15];
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			hist_q <= 15'h0000;
			dout   <= 32'h0000_0000;
			dvalid <= 1'b0;
		end
		else
		begin
			hist_q <= din[14:0];
			dout   <= scramble_on ? plain : din;
			dvalid <= lane_active;
		end
	end

endmodule // sllms_descr

// ---- rtl/sllms_top.v ----
// Purpose: Lane crossbar, link grouping, sync requests and latency readback for an 8-lane receiver.
// Assumes: CLK is the processing clock; lane words and flags are already on it.
// Notes: SYSREF is a pin and is synchronised before use.
`timescale 1ns/1ps
`include "sllms_defs.vh"
module sllms_top
(
	input  wire         CLK,
	input  wire         RST,
	input  wire [11:0]  REG_ADDR,
	input  wire [7:0]   REG_WDATA,
	input  wire         REG_WR,
	input  wire         REG_RD,
	output reg  [7:0]   REG_RDATA,
	output reg          REG_RVALID,
	input  wire [255:0] SERIAL_LANE_INPUT,
	input  wire [7:0]   LANE_SYNCED,
	input  wire [7:0]   LANE_MF_START,
	input  wire         SYSREF,
	output reg          LINK0_SYNC_REQUEST_OUT_N,
	output reg          LINK1_SYNC_REQUEST_OUT_N,
	output wire [255:0] DEFRAMED_DATA,
	output wire [7:0]   DEFRAMED_VALID,
	output reg          MF_RELEASE
);

	reg  [3:0]   link_ctrl_q;
	reg          subclass_q;
	reg  [23:0]  lane_source_select_q;
	reg  [5:0]   pcpmf_q;
	reg  [3:0]   varwin_q;
	reg  [4:0]   reldel_q;
	reg  [3:0]   mode_q;
	reg          scramble_q;
	reg  [10:0]  rate_q;
	reg  [5:0]   lmfc_q;
	reg  [2:0]   sysref_q;
	reg  [5:0]   lat_q [0:1];
	reg  [7:0]   seen_q [0:1];
	reg          done_q [0:1];
	reg          lat_valid_q [0:1];
	reg  [7:0]   rdata_d;
	reg  [3:0]   lanes_per_link;
	reg          mode_ok;
	wire [255:0] log_data;
	wire [7:0]   log_synced;
	wire [7:0]   log_mf;
	wire [1:0]   link_enable_mask   = link_ctrl_q[1:0];
	wire         status_link_select = link_ctrl_q[`SLLMS_CTRL_STAT_SEL];
	wire         two_link_mode      = link_ctrl_q[`SLLMS_CTRL_TWO_LINK];
	wire [7:0]   lane_run;
	wire [7:0]   member0;
	wire [7:0]   member1;
	wire         link0_on;
	wire         link1_on;
	wire         req0;
	wire         req1;
	wire         sysref_edge;
	wire         mf_wrap;
	wire         win_bad;
	wire         rate_bad;
	wire [7:0]   status_byte;
	wire         sel_synced;
	wire         sel_req;

	// Lane count per mode; mode 8 and modes above 10 give zero lanes.
	always @*
	begin
		case (mode_q)
			4'h0:    lanes_per_link = 4'h8;
			4'h1:    lanes_per_link = 4'h8;
			4'h2:    lanes_per_link = 4'h4;
			4'h3:    lanes_per_link = 4'h2;
			4'h4:    lanes_per_link = 4'h4;
			4'h5:    lanes_per_link = 4'h4;
			4'h6:    lanes_per_link = 4'h2;
			4'h7:    lanes_per_link = 4'h1;
			4'h9:    lanes_per_link = 4'h2;
			4'hA:    lanes_per_link = 4'h1;
			default: lanes_per_link = 4'h0;
		endcase
	end

	always @*
	begin
		mode_ok = (mode_q != `SLLMS_INVALID_MODE) && (mode_q <= `SLLMS_LAST_MODE);
		if (two_link_mode && (mode_q < `SLLMS_FIRST_DUAL_MODE))
			mode_ok = 1'b0;
	end

	// one or two links
	// In two-link mode link 1 owns lanes 4 up, else none; dual modes never exceed four lanes.
	assign member0 = mode_ok ? (8'hFF >> (4'h8 - lanes_per_link)) : 8'h00;
	assign member1 = two_link_mode ? {member0[3:0], 4'h0} : 8'h00;

	assign link0_on = link_enable_mask[0];
	assign link1_on = two_link_mode & link_enable_mask[1];

	// lane loss request
	// A disabled link or an illegal mode also keeps the request up.
	assign req0 = ~link0_on | ~mode_ok | ~(&(log_synced | ~member0));
	assign req1 = ~link1_on | ~mode_ok | ~(&(log_synced | ~member1));

	// transmitter holds sync characters while low
	always @(posedge CLK)
	begin
		if (RST)
		begin
			LINK0_SYNC_REQUEST_OUT_N <= 1'b0;
			LINK1_SYNC_REQUEST_OUT_N <= 1'b1;
		end
		else
		begin
			LINK0_SYNC_REQUEST_OUT_N <= ~req0;
			LINK1_SYNC_REQUEST_OUT_N <= two_link_mode ? ~req1 : 1'b1;
		end
	end

	// shared SYSREF synchroniser; stage two feeds the edge detector.
	always @(posedge CLK)
	begin
		if (RST)
			sysref_q <= 3'h0;
		else
			sysref_q <= {sysref_q[1:0], SYSREF};
	end
	assign sysref_edge = sysref_q[1] & ~sysref_q[2];

	// wrap at multiframe
	// Subclass 0 runs free, so its phase is only internally consistent.
	assign mf_wrap = (lmfc_q >= pcpmf_q - 6'h01);
	always @(posedge CLK)
	begin
		if (RST)
			lmfc_q <= 6'h00;
		else if (subclass_q && sysref_edge)
			lmfc_q <= 6'h00;
		else if (mf_wrap)
			lmfc_q <= 6'h00;
		else
			lmfc_q <= lmfc_q + 6'h01;
	end

	// Release strobe at the programmed delay into each multiframe.
	always @(posedge CLK)
	begin
		if (RST)
			MF_RELEASE <= 1'b0;
		else
			MF_RELEASE <= ({1'b0, reldel_q} == lmfc_q);
	end

	// latency capture
	// The count is latched when the last member lane reports its boundary.
	genvar k;
	generate
		for (k = 0; k < 2; k = k + 1)
		begin : g_link
			wire [7:0] mem  = (k == 0) ? member0 : member1;
			wire [7:0] seen = (mf_wrap ? 8'h00 : seen_q[k]) | (log_mf & mem);
			wire       full = (mem != 8'h00) && ((seen & mem) == mem);
			always @(posedge CLK)
			begin
				if (RST)
				begin
					seen_q[k]      <= 8'h00;
					done_q[k]      <= 1'b0;
					lat_q[k]       <= 6'h00;
					lat_valid_q[k] <= 1'b0;
				end
				else
				begin
					seen_q[k] <= seen;
					done_q[k] <= full & ~(mf_wrap & ~(|(log_mf & mem)));
					if (full && (!done_q[k] || mf_wrap))
					begin
						lat_q[k]       <= lmfc_q;
						lat_valid_q[k] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	assign win_bad  = (varwin_q > `SLLMS_MAX_VARWIN);
	assign rate_bad = (rate_q < `SLLMS_RATE_MIN_10M) || (rate_q > `SLLMS_RATE_MAX_10M);

	assign sel_synced  = status_link_select ? ~req1 : ~req0;
	assign sel_req     = status_link_select ? req1 : req0;
	assign status_byte = {2'b00, rate_bad, win_bad, ~mode_ok,
		lat_valid_q[status_link_select], sel_req, sel_synced};

	// Register writes; values are software's to choose.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			link_ctrl_q          <= `SLLMS_RST_LINK_CTRL;
			subclass_q           <= 1'b0;
			lane_source_select_q <= {3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0};
			pcpmf_q              <= `SLLMS_RST_PCPMF;
			varwin_q             <= `SLLMS_RST_VARWIN;
			reldel_q             <= `SLLMS_RST_RELDEL;
			mode_q               <= `SLLMS_RST_MODE;
			scramble_q           <= 1'b0;
			rate_q               <= `SLLMS_RST_RATE;
		end
		else if (REG_WR)
		begin
			case (REG_ADDR)
				`SLLMS_ADDR_LINK_CTRL: link_ctrl_q <= REG_WDATA[3:0];
				`SLLMS_ADDR_SUBCLASS:  subclass_q <= REG_WDATA[0];
				`SLLMS_ADDR_MAP_A:     lane_source_select_q[5:0] <= REG_WDATA[5:0];
				`SLLMS_ADDR_MAP_B:     lane_source_select_q[11:6] <= REG_WDATA[5:0];
				`SLLMS_ADDR_MAP_C:     lane_source_select_q[17:12] <= REG_WDATA[5:0];
				`SLLMS_ADDR_MAP_D:     lane_source_select_q[23:18] <= REG_WDATA[5:0];
				`SLLMS_ADDR_PCPMF:     pcpmf_q <= REG_WDATA[5:0];
				`SLLMS_ADDR_VARWIN:    varwin_q <= REG_WDATA[3:0];
				`SLLMS_ADDR_RELDEL:    reldel_q <= REG_WDATA[4:0];
				`SLLMS_ADDR_MODE:
				begin
					mode_q     <= REG_WDATA[3:0];
					scramble_q <= REG_WDATA[`SLLMS_MODE_SCRAMBLE];
				end
				`SLLMS_ADDR_RATE_LO:   rate_q[7:0] <= REG_WDATA;
				`SLLMS_ADDR_RATE_HI:   rate_q[10:8] <= REG_WDATA[2:0];
				default:               ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero.
	always @*
	begin
		case (REG_ADDR)
			`SLLMS_ADDR_LINK_CTRL: rdata_d = {4'h0, link_ctrl_q};
			`SLLMS_ADDR_SUBCLASS:  rdata_d = {7'h00, subclass_q};
			`SLLMS_ADDR_LAT0:      rdata_d = {2'b00, lat_q[0]};
			`SLLMS_ADDR_LAT1:      rdata_d = {2'b00, lat_q[1]};
			`SLLMS_ADDR_STATUS:    rdata_d = status_byte;
			`SLLMS_ADDR_MAP_A:     rdata_d = {2'b00, lane_source_select_q[5:0]};
			`SLLMS_ADDR_MAP_B:     rdata_d = {2'b00, lane_source_select_q[11:6]};
			`SLLMS_ADDR_MAP_C:     rdata_d = {2'b00, lane_source_select_q[17:12]};
			`SLLMS_ADDR_MAP_D:     rdata_d = {2'b00, lane_source_select_q[23:18]};
			`SLLMS_ADDR_PCPMF:     rdata_d = {2'b00, pcpmf_q};
			`SLLMS_ADDR_VARWIN:    rdata_d = {4'h0, varwin_q};
			`SLLMS_ADDR_RELDEL:    rdata_d = {3'b000, reldel_q};
			`SLLMS_ADDR_MODE:      rdata_d = {scramble_q, 3'b000, mode_q};
			`SLLMS_ADDR_RATE_LO:   rdata_d = rate_q[7:0];
			`SLLMS_ADDR_RATE_HI:   rdata_d = {5'h00, rate_q[10:8]};
			default:               rdata_d = 8'h00;
		endcase
	end

	// Read data is registered one cycle after the strobe.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RDATA  <= REG_RD ? rdata_d : 8'h00;
			REG_RVALID <= REG_RD;
		end
	end

	sllms_xbar u_xbar
	(
		.clk                (CLK),
		.rst                (RST),
		.phys_data          (SERIAL_LANE_INPUT),
		.phys_synced        (LANE_SYNCED),
		.phys_mf            (LANE_MF_START),
		.lane_source_select (lane_source_select_q),
		.log_data           (log_data),
		.log_synced         (log_synced),
		.log_mf             (log_mf)
	);

	// A lane delivers data only while its link is up and not resynchronising.
	assign lane_run = (member0 & {8{~req0}}) | (member1 & {8{~req1}});

	// descramble then deframe per logical lane
	genvar y;
	generate
		for (y = 0; y < 8; y = y + 1)
		begin : g_descr
			sllms_descr u_descr
			(
				.clk         (CLK),
				.rst         (RST),
				.scramble_on (scramble_q),
				.lane_active (lane_run[y]),
				.din         (log_data[32*y +: 32]),
				.dout        (DEFRAMED_DATA[32*y +: 32]),
				.dvalid      (DEFRAMED_VALID[y])
			);
		end
	endgenerate

endmodule // sllms_top

// ---- verif/sllms_tx_model.sv ----
// Purpose: Transmitter stand-in that feeds the eight physical lanes.
// Assumes: Sync requests are active low; lane health is set by the bench.
// Notes: Boundaries come every 32 cycles, matching the reset multiframe length.
`timescale 1ns/1ps
module sllms_tx_model
(
	input  wire         clk,
	input  wire         rst,
	input  wire         req0_n,
	input  wire         req1_n,
	input  wire         two_link,
	input  wire [7:0]   lane_ok,
	output reg  [255:0] lanes = 256'h0,
	output wire [7:0]   synced,
	output reg  [7:0]   mf = 8'h00
);
	reg     [7:0] cnt_q = 8'h00;
	integer       i;
	assign synced = lane_ok;
	// Each word carries its lane index and a running count, so a wrong route shows.
	// sync characters on request
	always @(posedge clk)
	begin
		cnt_q <= rst ? 8'h00 : cnt_q + 8'h01;
		mf    <= {8{cnt_q[4:0] == 5'h05}};
		for (i = 0; i < 8; i = i + 1)
			lanes[32*i +: 32] <= ((i > 3 && two_link) ? !req1_n : !req0_n) ?
				32'hBCBC_BCBC : {8'hD0 + i[7:0], 16'h0000, cnt_q};
	end
endmodule // sllms_tx_model

// ---- verif/sllms_top_monitor.sv ----
// Purpose: Port-level checks for the lane map and sync block.
// Assumes: Settings change only through the register port.
// Notes: Shadows a few settings so that replies can be judged.
`timescale 1ns/1ps
`include "sllms_defs.vh"
module sllms_top_monitor
(
	input wire        CLK,
	input wire        RST,
	input wire [11:0] REG_ADDR,
	input wire [7:0]  REG_WDATA,
	input wire        REG_WR,
	input wire        REG_RD,
	input wire [7:0]  REG_RDATA,
	input wire        REG_RVALID,
	input wire [7:0]  LANE_SYNCED,
	input wire        LINK0_SYNC_REQUEST_OUT_N,
	input wire        LINK1_SYNC_REQUEST_OUT_N,
	input wire [7:0]  DEFRAMED_VALID
);
	reg        two_q;
	reg [5:0]  pcpmf_q;
	reg [11:0] raddr_q;
	// The read address is kept one cycle, the time the reply takes to come back.
	always @(posedge CLK)
	begin
		raddr_q <= REG_ADDR;
		if (RST)
		begin
			two_q   <= 1'b0;
			pcpmf_q <= `SLLMS_RST_PCPMF;
		end
		else if (REG_WR && REG_ADDR == `SLLMS_ADDR_LINK_CTRL)
			two_q <= REG_WDATA[`SLLMS_CTRL_TWO_LINK];
		else if (REG_WR && REG_ADDR == `SLLMS_ADDR_PCPMF)
			pcpmf_q <= REG_WDATA[5:0];
	end
	default clocking mon_cb @(posedge CLK); endclocking
	default disable iff (RST);
	rd_answer_a: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered in one cycle");
	rdata_idle_a: assert property (!REG_RVALID |-> REG_RDATA == 8'h00)
		else $error("read data not zero while idle");
	link1_idle_a: assert property (!two_q && !$past(two_q) && !$past(two_q, 2)
		|-> LINK1_SYNC_REQUEST_OUT_N)
		else $error("second sync output used in single link");
	all_drop_a: assert property (LANE_SYNCED == 8'h00 ##1 LANE_SYNCED == 8'h00
		|=> !LINK0_SYNC_REQUEST_OUT_N)
		else $error("no sync request with all lanes lost");
	valid_drop_a: assert property (!LINK0_SYNC_REQUEST_OUT_N [*2]
		|-> DEFRAMED_VALID[0] == 1'b0)
		else $error("lane 0 valid during a sync request");
	lat_range_a: assert property (REG_RVALID && raddr_q == `SLLMS_ADDR_LAT0
		|-> REG_RDATA < {2'b00, pcpmf_q})
		else $error("latency beyond multiframe length");
	map_rsvd_a: assert property (REG_RVALID && raddr_q >= `SLLMS_ADDR_MAP_A
		&& raddr_q <= `SLLMS_ADDR_MAP_D |-> REG_RDATA[7:6] == 2'b00)
		else $error("crossbar spare bits not zero");
	map_wrrd_a: assert property (REG_WR && REG_ADDR == `SLLMS_ADDR_MAP_A ##1 !REG_WR
		##1 REG_RD && !REG_WR && REG_ADDR == `SLLMS_ADDR_MAP_A
		|=> REG_RDATA == ($past(REG_WDATA, 3) & 8'h3F))
		else $error("crossbar field not written");
	cover property ($fell(LINK1_SYNC_REQUEST_OUT_N));
	cover property ($rose(LINK0_SYNC_REQUEST_OUT_N));
	cover property (REG_RVALID && raddr_q == `SLLMS_ADDR_LAT0);
endmodule // sllms_top_monitor
bind sllms_top sllms_top_monitor u_mon
(
	.CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID,
	.LANE_SYNCED, .LINK0_SYNC_REQUEST_OUT_N, .LINK1_SYNC_REQUEST_OUT_N, .DEFRAMED_VALID
);

// ---- verif/sllms_top_tb.sv ----
// Purpose: Self-checking bench for the lane map and sync block.
// Assumes: The model feeds the lanes; the bench owns lane health.
// Notes: Scrambling is on only in t_descr; elsewhere it stays off, so routed words compare raw.
`timescale 1ns/1ps
`include "sllms_defs.vh"
module sllms_top_tb;
	reg          clk = 1'b0;
	reg          rst = 1'b1;
	reg  [11:0]  reg_addr = 12'h000;
	reg  [7:0]   reg_wdata = 8'h00;
	reg          reg_wr = 1'b0;
	reg          reg_rd = 1'b0;
	reg          sysref = 1'b0;
	reg          two_link = 1'b0;
	reg  [7:0]   lane_ok = 8'hFF;
	reg  [7:0]   rv;
	reg  [10:0]  rt;
	reg  [31:0]  w4;
	reg  [31:0]  w0;
	reg  [46:0]  sq;
	wire [7:0]   rdata;
	wire         rvalid;
	wire [255:0] lanes;
	wire [7:0]   synced;
	wire [7:0]   mf;
	wire         req0_n;
	wire         req1_n;
	wire [255:0] ddata;
	wire [7:0]   dvalid;
	wire         mf_rel;
	integer      error_cnt = 0;
	integer      tests_run = 0;
	integer      i;
	integer      j;
	always #20 clk = ~clk;
	sllms_top u_dut
	(
		.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.SERIAL_LANE_INPUT(lanes), .LANE_SYNCED(synced), .LANE_MF_START(mf),
		.SYSREF(sysref), .LINK0_SYNC_REQUEST_OUT_N(req0_n),
		.LINK1_SYNC_REQUEST_OUT_N(req1_n), .DEFRAMED_DATA(ddata),
		.DEFRAMED_VALID(dvalid), .MF_RELEASE(mf_rel)
	);
	sllms_tx_model u_tx
	(
		.clk(clk), .rst(rst), .req0_n(req0_n), .req1_n(req1_n), .two_link(two_link),
		.lane_ok(lane_ok), .lanes(lanes), .synced(synced), .mf(mf)
	);
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	task cyc(input integer n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task wr(input [11:0] a, input [7:0] d);
	begin
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	end
	endtask
	// The reply is due one cycle after the strobe; the loop only bounds a late one.
	task rd(input [11:0] a);
		integer n;
	begin
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		for (n = 0; n < 4 && rvalid !== 1'b1; n = n + 1)
			@(posedge clk) #1;
		rv = rdata;
	end
	endtask
	task t_reset;
	begin
		rd(`SLLMS_ADDR_LINK_CTRL);
		chk(rv, 8'h00);
		for (i = 0; i < 4; i = i + 1)
		begin
			rd(`SLLMS_ADDR_MAP_A + i);
			chk(rv, {2'b00, 3'(2 * i + 1), 3'(2 * i)});
		end
		rd(12'h305);
		chk(rv, 8'h00);
		chk(req1_n, 1'b1);
		chk(req0_n, 1'b0);
		chk(dvalid, 8'h00);
		$display("t_reset done");
	end
	endtask
	task t_route;
	begin
		wr(`SLLMS_ADDR_LINK_CTRL, 8'h01);
		wr(`SLLMS_ADDR_MAP_A, 8'hC4);
		rd(`SLLMS_ADDR_MAP_A);
		chk(rv, 8'h04);
		cyc(4);
		chk(req0_n, 1'b1);
		chk(dvalid, 8'hFF);
		w4 = lanes[159:128];
		w0 = lanes[31:0];
		cyc(2);
		chk(ddata[31:0], w4);
		chk(ddata[63:32], w0);
		wr(`SLLMS_ADDR_MAP_A, 8'h08);
		cyc(4);
		$display("t_route done");
	end
	endtask
	// Scrambled lane 0: each output bit undoes the bits fourteen and fifteen places earlier.
	task t_descr;
	begin
		wr(`SLLMS_ADDR_MODE, 8'h80);
		cyc(4);
		w0 = lanes[31:0];
		cyc(1);
		w4 = lanes[31:0];
		sq = {w0[14:0], w4};
		cyc(2);
		chk(ddata[31:0], w4 ^ sq[45:14] ^ sq[46:15]);
		wr(`SLLMS_ADDR_MODE, 8'h00);
		$display("t_descr done");
	end
	endtask
	task t_sync;
	begin
		@(posedge clk);
		lane_ok <= 8'hF7;
		cyc(2);
		chk(req0_n, 1'b0);
		cyc(1);
		chk(lanes[31:0], 32'hBCBC_BCBC);
		chk(dvalid, 8'h00);
		@(posedge clk);
		lane_ok <= 8'h00;
		cyc(3);
		@(posedge clk);
		lane_ok <= 8'hFF;
		cyc(4);
		chk(req0_n, 1'b1);
		$display("t_sync done");
	end
	endtask
	task t_dual;
	begin
		wr(`SLLMS_ADDR_MODE, 8'h04);
		two_link <= 1'b1;
		wr(`SLLMS_ADDR_LINK_CTRL, 8'h0B);
		cyc(4);
		chk({req1_n, req0_n}, 2'b11);
		@(posedge clk);
		lane_ok <= 8'hDF;
		cyc(2);
		chk({req1_n, req0_n}, 2'b01);
		wr(`SLLMS_ADDR_LINK_CTRL, 8'h0F);
		rd(`SLLMS_ADDR_STATUS);
		chk(rv[1:0], 2'b10);
		wr(`SLLMS_ADDR_LINK_CTRL, 8'h0B);
		rd(`SLLMS_ADDR_STATUS);
		chk(rv[1:0], 2'b01);
		@(posedge clk);
		lane_ok <= 8'hFF;
		two_link <= 1'b0;
		wr(`SLLMS_ADDR_LINK_CTRL, 8'h01);
		$display("t_dual done");
	end
	endtask
	task t_modes;
	begin
		for (j = 0; j < 2; j = j + 1)
		begin
			wr(`SLLMS_ADDR_LINK_CTRL, j ? 8'h0B : 8'h01);
			for (i = 0; i <= 11; i = i + 1)
			begin
				wr(`SLLMS_ADDR_MODE, i[7:0]);
				rd(`SLLMS_ADDR_STATUS);
				chk(rv[3], i == 8 || i > 10 || (j == 1 && i < 4));
			end
		end
		wr(`SLLMS_ADDR_MODE, 8'h00);
		wr(`SLLMS_ADDR_LINK_CTRL, 8'h01);
		$display("t_modes done");
	end
	endtask
	task t_limits;
	begin
		for (i = 10; i < 12; i = i + 1)
		begin
			wr(`SLLMS_ADDR_VARWIN, i[7:0]);
			rd(`SLLMS_ADDR_STATUS);
			chk(rv[4], i == 11);
		end
		wr(`SLLMS_ADDR_VARWIN, 8'h00);
		for (i = 0; i < 4; i = i + 1)
		begin
			rt = (i == 0) ? 11'h08F : (i == 1) ? 11'h090 : (i == 2) ? 11'h4D8 : 11'h4D9;
			wr(`SLLMS_ADDR_RATE_LO, rt[7:0]);
			wr(`SLLMS_ADDR_RATE_HI, {5'h00, rt[10:8]});
			rd(`SLLMS_ADDR_STATUS);
			chk(rv[5], i == 0 || i == 3);
		end
		$display("t_limits done");
	end
	endtask
	// Counts release strobes over two full multiframes of the reset length.
	task cnt_rel;
	begin
		cyc(1);
		j = 0;
		repeat (64)
		begin
			j = j + mf_rel;
			cyc(1);
		end
	end
	endtask
	// The release delay is set from the reading, the way software would.
	task t_latency;
	begin
		wr(`SLLMS_ADDR_SUBCLASS, 8'h01);
		@(posedge clk);
		sysref <= 1'b1;
		repeat (4) @(posedge clk);
		sysref <= 1'b0;
		cyc(80);
		rd(`SLLMS_ADDR_STATUS);
		chk(rv[2], 1'b1);
		rd(`SLLMS_ADDR_LAT0);
		chk(rv < 8'h20, 1'b1);
		// Readings close to zero are taken as having wrapped past the multiframe end.
		if (rv < 8'h04)
			rv = rv + 8'h20;
		// One register serves both links, so one write programs every link alike.
		wr(`SLLMS_ADDR_VARWIN, 8'h02);
		// Mode 0 carries four frames per processing clock and K is 32.
		wr(`SLLMS_ADDR_RELDEL, ((rv - 8'h01) * 8'h04) & 8'h1F);
		cnt_rel;
		chk(j, 2);
		wr(`SLLMS_ADDR_SUBCLASS, 8'h00);
		wr(`SLLMS_ADDR_RELDEL, (rv - 8'h01) & 8'h1F);
		cnt_rel;
		chk(j, 2);
		$display("t_latency done");
	end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_route;
		t_descr;
		t_sync;
		t_dual;
		t_modes;
		t_limits;
		t_latency;
		end_sim;
	end
	// The tests need about 460 cycles; the watchdog allows 5,000.
	initial
	begin
		#200000;
		error_cnt = error_cnt + 1;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim;
	end
endmodule // sllms_top_tb
